/* stepper_pkg.sv */
// constants shared by the stepper phase sequencer files
`default_nettype none

package stepper_pkg;

   // ****************************************
   // register map and layout
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h0C;

   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_RESTART_BIT = 1;
   localparam int STAT_POS_LSB = 0;
   localparam int STAT_FAULT_BIT = 3;
   localparam int STAT_HALF_BIT = 4;
   localparam int STAT_DIR_BIT = 5;
   localparam int STAT_WIND_LSB = 8;
   localparam int INT_STEP_BIT = 0;
   localparam int INT_FAULT_BIT = 1;
   localparam int INT_W = 2;

   localparam logic RST_CTRL_ENABLE = 1'b1;
   localparam logic [INT_W-1:0] RST_INT_MASK = 2'h0;

   // ****************************************
   // sequencer
   // ****************************************
   localparam int POS_W = 3;
   localparam logic [POS_W-1:0] INIT_POS = 3'h0;
   localparam logic [3:0] INIT_WINDINGS = 4'h9;
   localparam logic [POS_W-1:0] STRIDE_HALF = 3'h1;
   localparam logic [POS_W-1:0] STRIDE_FULL = 3'h2;

   // ****************************************
   // axi responses
   // ****************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* step_edge_detect.sv */
// qualifying step clock edge detector
`default_nettype none
`timescale 1ns/1ps

module step_edge_detect (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // step input
   input wire logic step_clk,
   input wire logic edge_select,
   // qualified edge
   output logic step_pulse
);
   import stepper_pkg::*;

   typedef struct packed {
      logic prev;
   } edge_state_s;

   edge_state_s state_ff;
   edge_state_s nxt_state;

   always_comb begin
      nxt_state.prev = step_clk;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // falling edge only when edge_select low
   assign step_pulse = (step_clk & ~state_ff.prev) | (~edge_select & ~step_clk & state_ff.prev);

endmodule

`default_nettype wire

/* phase_decode.sv */
// excitation position to winding pattern table
`default_nettype none
`timescale 1ns/1ps

module phase_decode (
   // position
   input wire logic [stepper_pkg::POS_W-1:0] pos,
   // windings, bit0 out_one .. bit3 out_four
   output logic [3:0] windings
);
   import stepper_pkg::*;

   // even positions two windings, odd positions one
   always_comb begin
      unique case (pos)
         3'h0: windings = INIT_WINDINGS;
         3'h1: windings = 4'h1;
         3'h2: windings = 4'h5;
         3'h3: windings = 4'h4;
         3'h4: windings = 4'h6;
         3'h5: windings = 4'h2;
         3'h6: windings = 4'hA;
         3'h7: windings = 4'h8;
      endcase
   end

endmodule

`default_nettype wire

/* stepper_phase_sequencer.sv */
// stepper phase sequencer with axi4-lite register access
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
`timescale 1ns/1ps

// Summary of operation
// - with edge_select high, advance one step per rising step clock edge only.
// - edge_select low advances on both rising and falling step clock edges.
// - excitation_select low gives full-step, high gives half-step excitation.
// - direction_select low steps forward, high steps in reverse.
// - while reset_n_in is low the sequencer is held in reset.
// - releasing reset_n_in starts at the position with out_one and out_four on.
// - enable low forces all four winding outputs off.
// - enable high again resumes at the position reached, which kept stepping while enable was low, no sequence reset.
// - fault_n goes low once overcurrent or overheat detection fires.
// - a detected fault latches windings off until reset_n_in pulses low.
module stepper_phase_sequencer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // motion controller inputs
   input wire logic step_clk,
   input wire logic excitation_select,
   input wire logic edge_select,
   input wire logic direction_select,
   input wire logic reset_n_in,
   input wire logic enable,
   // protection detectors
   input wire logic overcurrent_det,
   input wire logic overheat_det,
   // winding outputs
   output logic out_one,
   output logic out_two,
   output logic out_three,
   output logic out_four,
   // status
   output logic fault_n,
   output logic irq,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [stepper_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [stepper_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   import stepper_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [POS_W-1:0] pos;
      logic fault_n;
      logic [3:0] windings;
      logic ctrl_enable;
      logic ctrl_restart;
      logic [INT_W-1:0] int_status;
      logic [INT_W-1:0] int_mask;
      logic irq;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } seq_state_s;

   seq_state_s state_ff;
   seq_state_s nxt_state;

   logic step_pulse;
   logic [3:0] table_windings;
   logic do_write;
   logic [INT_W-1:0] int_clear;
   logic [INT_W-1:0] int_set;
   logic [POS_W-1:0] stride;
   logic step_taken;
   logic fault_event;
   logic detect;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      is_mapped = (addr == OFS_CTRL) || (addr == OFS_STATUS) ||
                  (addr == OFS_INT_STATUS) || (addr == OFS_INT_MASK);
   endfunction

   // ****************************************
   // submodules
   // ****************************************
   step_edge_detect u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .step_clk(step_clk),
      .edge_select(edge_select),
      .step_pulse(step_pulse)
   );

   phase_decode u_decode (
      .pos(state_ff.pos),
      .windings(table_windings)
   );

   // ****************************************
   // bus handshakes
   // ****************************************
   assign awready = ~state_ff.aw_held & ~state_ff.bvalid;
   assign wready = ~state_ff.w_held & ~state_ff.bvalid;
   assign arready = ~state_ff.rvalid;
   assign do_write = state_ff.aw_held & state_ff.w_held;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_state.ctrl_restart = 1'b0;
      int_clear = '0;
      detect = overcurrent_det | overheat_det;

      // write channel capture, either order
      if (awvalid && awready) begin
         nxt_state.aw_held = 1'b1;
         nxt_state.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         nxt_state.w_held = 1'b1;
         nxt_state.w_data = wdata;
         nxt_state.w_strb = wstrb;
      end
      if (do_write) begin
         nxt_state.aw_held = 1'b0;
         nxt_state.w_held = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp = is_mapped(state_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (state_ff.w_strb[0]) begin
            unique case (state_ff.aw_addr)
               OFS_CTRL: begin
                  nxt_state.ctrl_enable = state_ff.w_data[CTRL_ENABLE_BIT];
                  nxt_state.ctrl_restart = state_ff.w_data[CTRL_RESTART_BIT];
               end
               OFS_INT_STATUS: begin
                  int_clear = state_ff.w_data[INT_W-1:0];
               end
               OFS_INT_MASK: begin
                  nxt_state.int_mask = state_ff.w_data[INT_W-1:0];
               end
               default: begin
               end
            endcase
         end
      end else if (state_ff.bvalid && bready) begin
         nxt_state.bvalid = 1'b0;
      end

      // read channel
      if (arvalid && arready) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         nxt_state.rdata = '0;
         unique case (araddr)
            OFS_CTRL: begin
               nxt_state.rdata[CTRL_ENABLE_BIT] = state_ff.ctrl_enable;
            end
            OFS_STATUS: begin
               nxt_state.rdata[STAT_POS_LSB +: POS_W] = state_ff.pos;
               nxt_state.rdata[STAT_FAULT_BIT] = ~state_ff.fault_n;
               nxt_state.rdata[STAT_HALF_BIT] = excitation_select;
               nxt_state.rdata[STAT_DIR_BIT] = direction_select;
               nxt_state.rdata[STAT_WIND_LSB +: 4] = state_ff.windings;
            end
            OFS_INT_STATUS: begin
               nxt_state.rdata[INT_W-1:0] = state_ff.int_status;
            end
            OFS_INT_MASK: begin
               nxt_state.rdata[INT_W-1:0] = state_ff.int_mask;
            end
            default: begin
            end
         endcase
      end else if (state_ff.rvalid && rready) begin
         nxt_state.rvalid = 1'b0;
      end

      // full-step from an odd position lands on two-winding state
      if (excitation_select || state_ff.pos[0]) begin
         stride = STRIDE_HALF;
      end else begin
         stride = STRIDE_FULL;
      end

      step_taken = 1'b0;
      fault_event = 1'b0;
      if (!reset_n_in) begin
         nxt_state.pos = INIT_POS;
         nxt_state.fault_n = 1'b1;
      end else begin
         if (detect) begin
            nxt_state.fault_n = 1'b0;
            fault_event = state_ff.fault_n;
         end
         if (state_ff.ctrl_restart) begin
            nxt_state.pos = INIT_POS;
         end else if (step_pulse && state_ff.fault_n) begin
            // position keeps running while enable is low
            // position moves only on a qualifying edge
            step_taken = 1'b1;
            if (direction_select) begin
               nxt_state.pos = state_ff.pos - stride;
            end else begin
               nxt_state.pos = state_ff.pos + stride;
            end
         end
      end

      // pos zero decodes to out_one and out_four
      if (reset_n_in && state_ff.fault_n && enable && state_ff.ctrl_enable) begin
         nxt_state.windings = table_windings;
      end else begin
         nxt_state.windings = 4'h0;
      end

      // sticky events, set wins over clear
      int_set = '0;
      int_set[INT_STEP_BIT] = step_taken;
      int_set[INT_FAULT_BIT] = fault_event;
      nxt_state.int_status = (state_ff.int_status & ~int_clear) | int_set;
      nxt_state.irq = |(nxt_state.int_status & nxt_state.int_mask);
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= '0;
         state_ff.pos <= INIT_POS;
         state_ff.fault_n <= 1'b1;
         state_ff.ctrl_enable <= RST_CTRL_ENABLE;
         state_ff.int_mask <= RST_INT_MASK;
         state_ff.bresp <= RESP_OKAY;
         state_ff.rresp <= RESP_OKAY;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign out_one = state_ff.windings[0];
   assign out_two = state_ff.windings[1];
   assign out_three = state_ff.windings[2];
   assign out_four = state_ff.windings[3];
   assign fault_n = state_ff.fault_n;
   assign irq = state_ff.irq;
   assign bvalid = state_ff.bvalid;
   assign bresp = state_ff.bresp;
   assign rvalid = state_ff.rvalid;
   assign rdata = state_ff.rdata;
   assign rresp = state_ff.rresp;

   // ****************************************
   // checks
   // ****************************************
   // rising edge moves position
   chk_rise_step: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (edge_select && step_clk && !$past(step_clk) && reset_n_in && fault_n && !state_ff.ctrl_restart)
      |=> (state_ff.pos != $past(state_ff.pos)))
      else $error("rising step edge did not move position");
   // falling edge ignored in rising-only mode
   chk_fall_ignored: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (edge_select && !step_clk && $past(step_clk) && reset_n_in && !state_ff.ctrl_restart)
      |=> $stable(state_ff.pos))
      else $error("falling edge moved position with edge_select high");
   chk_half_stride: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (excitation_select && !direction_select && step_pulse && reset_n_in && fault_n && !state_ff.ctrl_restart)
      |=> (state_ff.pos == $past(state_ff.pos) + 3'h1))
      else $error("half-step forward stride wrong");
   chk_dir_reverse: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (excitation_select && direction_select && step_pulse && reset_n_in && fault_n && !state_ff.ctrl_restart)
      |=> (state_ff.pos == $past(state_ff.pos) - 3'h1))
      else $error("reverse step went the wrong way");
   chk_reset_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !reset_n_in |=> (state_ff.pos == INIT_POS) && (state_ff.windings == 4'h0) && fault_n)
      else $error("reset_n_in low did not hold reset state");
   chk_init_phase: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!$past(reset_n_in) && reset_n_in && enable && state_ff.ctrl_enable)
      |=> ({out_four, out_three, out_two, out_one} == INIT_WINDINGS))
      else $error("initial winding pattern wrong after reset release");
   chk_enable_off: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !enable |=> !out_one && !out_two && !out_three && !out_four)
      else $error("windings on while enable low");
   chk_enable_keep: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!enable && reset_n_in && !step_pulse && !state_ff.ctrl_restart)
      ##1 (enable && reset_n_in && !step_pulse && !state_ff.ctrl_restart)
      |-> (state_ff.pos == $past(state_ff.pos, 2)))
      else $error("position lost across enable low");
   chk_fault_flag: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ((overcurrent_det || overheat_det) && reset_n_in) |=> !fault_n)
      else $error("fault flag not asserted on detection");
   chk_fault_latch: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!fault_n && reset_n_in) |=> !fault_n && (state_ff.windings == 4'h0))
      else $error("fault latch released or windings on");
   chk_full_even: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!excitation_select && step_pulse && reset_n_in && fault_n)
      |=> !state_ff.pos[0])
      else $error("full-step landed on single-winding state");
   chk_hold_pos: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!step_pulse && reset_n_in && !state_ff.ctrl_restart) |=> $stable(state_ff.pos))
      else $error("position moved without qualifying edge");

endmodule

`default_nettype wire

/* motion_ctrl_model.sv */
// motion controller model driving step clock and control levels
`timescale 1ns/1ps
`default_nettype none

module motion_ctrl_model (
   // clock
   input wire logic aclk,
   // control levels
   output logic step_clk,
   output logic excitation_select,
   output logic edge_select,
   output logic direction_select,
   output logic reset_n_in,
   output logic enable
);
   initial begin
      step_clk = 1'b0;
      excitation_select = 1'b0;
      edge_select = 1'b1;
      direction_select = 1'b0;
      reset_n_in = 1'b0;
      enable = 1'b1;
   end

   // each level stands at least five cycles
   task automatic toggle_step();
      @(posedge aclk);
      step_clk <= ~step_clk;
      repeat (4) @(posedge aclk);
   endtask

   task automatic set_levels(input logic ex, input logic ed, input logic dir);
      @(posedge aclk);
      excitation_select <= ex;
      edge_select <= ed;
      direction_select <= dir;
      repeat (2) @(posedge aclk);
   endtask

   task automatic set_enable(input logic v);
      @(posedge aclk);
      enable <= v;
      repeat (3) @(posedge aclk);
   endtask

   task automatic set_reset(input logic v);
      @(posedge aclk);
      reset_n_in <= v;
      repeat (v ? 1000 : 3) @(posedge aclk);
   endtask
endmodule

`default_nettype wire

/* test_stepper_phase_sequencer.sv */
// self-checking testbench of the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none

module test_stepper_phase_sequencer;
   import stepper_pkg::*;
   logic aclk, aresetn, step_clk, excitation_select, edge_select, direction_select, reset_n_in, enable;
   logic overcurrent_det, overheat_det, out_one, out_two, out_three, out_four, fault_n, irq;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, seed, rd;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] wind, wstrb;
   logic [2:0] exp_pos, prot;
   int errors, n_compared;
   assign wind = {out_four, out_three, out_two, out_one};

   stepper_phase_sequencer i_stepper_phase_sequencer (.aclk(aclk), .aresetn(aresetn), .step_clk(step_clk),
      .excitation_select(excitation_select), .edge_select(edge_select), .direction_select(direction_select),
      .reset_n_in(reset_n_in), .enable(enable), .overcurrent_det(overcurrent_det), .overheat_det(overheat_det),
      .out_one(out_one), .out_two(out_two), .out_three(out_three), .out_four(out_four), .fault_n(fault_n),
      .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(prot), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp));

   motion_ctrl_model i_motion_ctrl_model (.aclk(aclk), .step_clk(step_clk),
      .excitation_select(excitation_select), .edge_select(edge_select), .direction_select(direction_select),
      .reset_n_in(reset_n_in), .enable(enable));

   // ****************************************
   // expectation functions
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic logic [3:0] wind_of(input logic [2:0] p);
      logic [3:0] t [8] = '{4'h9, 4'h1, 4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8};
      return t[p];
   endfunction

   function automatic logic [2:0] next_pos(input logic [2:0] p, input logic half, input logic dir);
      logic [2:0] d;
      d = (half || p[0]) ? 3'h1 : 3'h2;
      return dir ? p - d : p + d;
   endfunction

   // ****************************************
   // compare and verdict
   // ****************************************
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_wind(input logic [3:0] e);
      n_compared++;
      if (wind !== e) begin
         errors++;
         $display("[ERR] windings expected %h seen %h", e, wind);
      end
   endtask

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic give_verdict();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ****************************************
   // axi4-lite master
   // ****************************************
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, sa, sw, tb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
         @(negedge aclk);
         sa = awvalid & awready;
         sw = wvalid & wready;
         @(posedge aclk);
         if (sa) awvalid <= 1'b0;
         if (sw) wvalid <= 1'b0;
         ta = ta | sa;
         tw = tw | sw;
      end
      bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge aclk);
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
      end
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic sa, tb;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      sa = 1'b0;
      while (!sa) begin
         @(negedge aclk);
         sa = arready;
         @(posedge aclk);
      end
      arvalid <= 1'b0;
      rready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge aclk);
         tb = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
      end
      rready <= 1'b0;
   endtask

   // one step clock level change and the windings it should give
   task automatic do_step(input logic acc, input logic drv);
      if (acc && (!step_clk || !edge_select))
         exp_pos = next_pos(exp_pos, excitation_select, direction_select);
      i_motion_ctrl_model.toggle_step();
      chk_wind(drv ? wind_of(exp_pos) : 4'h0);
   endtask

   // ****************************************
   // clock, watchdog, sequence
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      repeat (40000) @(posedge aclk);
      errors++;
      give_verdict();
   end

   initial begin
      {aresetn, overcurrent_det, overheat_det, awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      prot = 3'h0;
      errors = 0;
      n_compared = 0;
      seed = 32'h81E1892D;
      exp_pos = INIT_POS;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      i_motion_ctrl_model.set_reset(1'b1);
      chk_wind(INIT_WINDINGS);
      axi_read(OFS_CTRL, rd, resp);
      chk_word("ctrl", 32'h1, rd);
      axi_read(OFS_INT_MASK, rd, resp);
      chk_word("int_mask", 32'h0, rd);
      for (int i = 0; i < 64; i++) begin
         seed = xs(seed);
         prot <= seed[5:3];
         i_motion_ctrl_model.set_levels(seed[0], seed[1], seed[2]);
         do_step(1'b1, 1'b1);
      end
      axi_read(OFS_STATUS, rd, resp);
      chk_word("status", {20'h0, wind_of(exp_pos), 2'b00, direction_select, excitation_select, 1'b0, exp_pos}, rd);
      i_motion_ctrl_model.set_enable(1'b0);
      chk_wind(4'h0);
      do_step(1'b1, 1'b0);
      do_step(1'b1, 1'b0);
      i_motion_ctrl_model.set_enable(1'b1);
      chk_wind(wind_of(exp_pos));
      axi_write(OFS_CTRL, 32'h0, resp);
      repeat (3) @(posedge aclk);
      chk_wind(4'h0);
      axi_write(OFS_CTRL, 32'h3, resp);
      exp_pos = INIT_POS;
      repeat (3) @(posedge aclk);
      chk_wind(INIT_WINDINGS);
      chk_word("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      // byte lane zero off: write answered but ignored
      wstrb <= 4'hE;
      axi_write(OFS_CTRL, 32'h0, resp);
      wstrb <= 4'hF;
      repeat (3) @(posedge aclk);
      chk_wind(INIT_WINDINGS);
      chk_word("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      i_motion_ctrl_model.set_reset(1'b0);
      do_step(1'b0, 1'b0);
      i_motion_ctrl_model.set_reset(1'b1);
      chk_wind(INIT_WINDINGS);
      i_motion_ctrl_model.set_levels(1'b1, 1'b0, 1'b0);
      axi_write(OFS_INT_STATUS, 32'h3, resp);
      axi_write(OFS_INT_MASK, 32'h0, resp);
      do_step(1'b1, 1'b1);
      chk_bit("irq", 1'b0, irq);
      axi_write(OFS_INT_MASK, 32'h1, resp);
      repeat (3) @(posedge aclk);
      chk_bit("irq", 1'b1, irq);
      axi_read(OFS_INT_STATUS, rd, resp);
      chk_word("int_status", 32'h1, rd);
      axi_write(OFS_INT_STATUS, 32'h1, resp);
      repeat (3) @(posedge aclk);
      chk_bit("irq", 1'b0, irq);
      for (int k = 0; k < 2; k++) begin
         axi_write(OFS_INT_MASK, 32'h2, resp);
         @(posedge aclk);
         overcurrent_det <= (k == 0);
         overheat_det <= (k == 1);
         repeat (3) @(posedge aclk);
         overcurrent_det <= 1'b0;
         overheat_det <= 1'b0;
         repeat (3) @(posedge aclk);
         chk_bit("fault_n", 1'b0, fault_n);
         chk_wind(4'h0);
         chk_bit("irq", 1'b1, irq);
         do_step(1'b0, 1'b0);
         axi_read(OFS_INT_STATUS, rd, resp);
         chk_word("int_status", 32'h2, rd);
         axi_write(OFS_INT_STATUS, 32'h2, resp);
         repeat (3) @(posedge aclk);
         chk_bit("irq", 1'b0, irq);
         i_motion_ctrl_model.set_reset(1'b0);
         i_motion_ctrl_model.set_reset(1'b1);
         exp_pos = INIT_POS;
         chk_bit("fault_n", 1'b1, fault_n);
         chk_wind(INIT_WINDINGS);
      end
      axi_read(8'h40, rd, resp);
      chk_word("unmapped rdata", 32'h0, rd);
      chk_word("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      axi_write(8'h40, 32'hFF, resp);
      chk_word("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      give_verdict();
   end
endmodule

`default_nettype wire
